// ---- hdl/fbs_sequencer.sv ----
// Operation
// - only linear word order, fixed bit
// - length codes select 4, 8, 16 words
// - code 7 continuous, never wraps
// - continuous runs to end of range
// - wrap keeps aligned group of start
// - no-wrap increments across group boundaries
// - wrap setting orders fixed lengths only, but gates row delay for all
// - clock-edge bit selects active edge
// - active edge starts, presents, moves wait
// - no-wrap may wait at first row crossing
// - row delay only with one-clock hold
// - aligned start gives no row delay
// - last-word start waits at most latency-1
// - row delay at most once per burst
// - wait held high; host waits too
// - misaligned waits follow latency and offset
// - sync bursts only with read mode cleared
// - latency counts edges to first word
// - wait asserted until data valid
// - data hold: two clocks or one
`timescale 1ns/1ns

module fbs_sequencer import fbs_pkg::*; #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RESET_N,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // burst link from the host
   input  wire logic              BURST_CLK,
   input  wire logic              ADV_N,
   input  wire logic              CE_N,
   input  wire logic [ADDR_W-1:0] ADDR,
   // array read port
   output logic      [ADDR_W-1:0] ARR_ADDR,
   input  wire logic [DATA_W-1:0] ARR_DATA,
   // data and wait pins
   output logic      [DATA_W-1:0] DQ_O,
   output logic                   DQ_OE_N,
   output logic                   WAIT_O,
   output logic                   WAIT_OE_N
);

   fbs_pin_if #(.ADDR_W(ADDR_W)) pin ();
   fbs_cfg_if                    cfg_if ();

   fbs_state_t        state_r;
   logic [ADDR_W-1:0] addr_r;
   logic [1:0]        off_r;
   logic [4:0]        words_r;
   logic [2:0]        lat_r;
   logic [2:0]        rw_r;
   logic [2:0]        rw_done_r;
   logic              hold_r;
   logic              crossed_r;
   logic              ld_r;
   logic              wait_r;
   logic              drive_r;
   logic [DATA_W-1:0] dq_r;
   // burst settings frozen at the start edge
   logic [2:0]        lc_q;
   logic [2:0]        bl_q;
   logic              bw_q;
   logic              dh_q;

   logic              rm;
   logic              cont;
   logic              step;
   logic              last;
   logic              start;
   logic              go_row;
   logic [ADDR_W-1:0] nxt_a;
   logic [2:0]        waits;

   fbs_pin_sync #(.ADDR_W(ADDR_W)) u_sync (
      .CLK       (CLK),
      .RESET_N   (RESET_N),
      .BURST_CLK (BURST_CLK),
      .ADV_N     (ADV_N),
      .CE_N      (CE_N),
      .ADDR      (ADDR),
      .rise_sel  (cfg_if.cfg[CE_BIT]),
      .pin       (pin)
   );

   fbs_apb_regs u_regs (
      .CLK     (CLK),
      .RESET_N (RESET_N),
      .PSEL    (PSEL),
      .PENABLE (PENABLE),
      .PWRITE  (PWRITE),
      .PADDR   (PADDR),
      .PWDATA  (PWDATA),
      .PRDATA  (PRDATA),
      .PREADY  (PREADY),
      .PSLVERR (PSLVERR),
      .cfg_if  (cfg_if)
   );

   // burst length in words; reserved codes behave as continuous
   function automatic logic [4:0] burst_words(input logic [2:0] bl);
      case (bl)
         BL_4:    return 5'h04;
         BL_8:    return 5'h08;
         BL_16:   return 5'h10;
         default: return 5'h00;
      endcase
   endfunction : burst_words

   // one word forward; in wrap mode with a fixed length only the group's low bits move
   function automatic logic [ADDR_W-1:0] next_addr(
      input logic [ADDR_W-1:0] a,
      input logic [2:0]        bl,
      input logic              bw);
      logic [ADDR_W-1:0] msk;
      logic [ADDR_W-1:0] inc;
      msk = ADDR_W'(burst_words(bl)) - ADDR_W'(1);
      inc = a + ADDR_W'(1);
      if (bw || burst_words(bl) == 5'h00)
         return inc;
      return (a & ~msk) | (inc & msk);
   endfunction : next_addr

   assign rm    = cfg_if.cfg[RM_BIT];
   assign cont  = (burst_words(bl_q) == 5'h00);
   assign start = pin.ev && !pin.adv_n && !pin.ce_n && !rm
                  && (state_r == ST_IDLE || state_r == ST_DONE);
   // a word is left after its data cycle: one edge, or two with hold set
   assign step  = (state_r == ST_DATA) && pin.ev && (!dh_q || hold_r);
   assign last  = cont ? (addr_r == '1) : (words_r == 5'h01);
   assign nxt_a = next_addr(addr_r, bl_q, bw_q);
   assign waits = fbs_row_waits(lc_q, off_r);
   assign go_row = step && !last && bw_q && !dh_q && !crossed_r
                   && nxt_a[3:0] == ROW_START && waits != 3'h0;

   // burst state; moves only on the active edge or chip deselect
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= ST_IDLE;
      end else if (pin.ce_n) begin
         state_r <= ST_IDLE;
      end else if (start) begin
         state_r <= ST_LAT;
      end else begin
         case (state_r)
            ST_LAT:
               if (pin.ev && lat_r == 3'h1)
                  state_r <= ST_DATA;
            ST_DATA:
               if (step && last)
                  state_r <= ST_DONE;
               else if (go_row)
                  state_r <= ST_ROWW;
            ST_ROWW:
               if (pin.ev && rw_r == 3'h1)
                  state_r <= ST_DATA;
            ST_IDLE, ST_DONE: state_r <= state_r;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // address, word count and settings captured at the start edge
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         addr_r  <= '0;
         off_r   <= 2'h0;
         words_r <= 5'h0;
         lc_q    <= 3'h0;
         bl_q    <= 3'h0;
         bw_q    <= 1'b0;
         dh_q    <= 1'b0;
      end else if (start) begin
         addr_r  <= pin.addr;
         off_r   <= pin.addr[1:0];
         words_r <= burst_words(cfg_if.cfg[BL_LSB +: 3]);
         lc_q    <= cfg_if.cfg[LC_LSB +: 3];
         bl_q    <= cfg_if.cfg[BL_LSB +: 3];
         bw_q    <= cfg_if.cfg[BW_BIT];
         dh_q    <= cfg_if.cfg[DH_BIT];
      end else if (step && !last) begin
         addr_r  <= nxt_a;
         words_r <= words_r - 5'h01;
      end
   end

   // latency, hold phase and row-crossing wait counters
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lat_r     <= 3'h0;
         hold_r    <= 1'b0;
         rw_r      <= 3'h0;
         rw_done_r <= 3'h0;
         crossed_r <= 1'b0;
      end else if (start) begin
         lat_r     <= cfg_if.cfg[LC_LSB +: 3];
         hold_r    <= 1'b0;
         rw_done_r <= 3'h0;
         crossed_r <= 1'b0;
      end else begin
         if (state_r == ST_LAT && pin.ev)
            lat_r <= lat_r - 3'h1;
         if (state_r == ST_DATA && pin.ev)
            hold_r <= step ? 1'b0 : 1'b1;
         if (step && !last && nxt_a[3:0] == ROW_START)
            crossed_r <= 1'b1;
         if (go_row) begin
            rw_r      <= waits;
            rw_done_r <= waits;
         end else if (state_r == ST_ROWW && pin.ev)
            rw_r <= rw_r - 3'h1;
      end
   end

   // load strobe: next word is fetched one cycle after presentation
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         ld_r <= 1'b0;
      else
         ld_r <= !pin.ce_n && pin.ev
                 && ((state_r == ST_LAT && lat_r == 3'h1)
                     || (step && !last && !go_row)
                     || (state_r == ST_ROWW && rw_r == 3'h1));
   end

   // pins: wait high through latency and row waits, low with data
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dq_r    <= '0;
         wait_r  <= 1'b0;
         drive_r <= 1'b0;
      end else if (pin.ce_n) begin
         wait_r  <= 1'b0;
         drive_r <= 1'b0;
      end else if (start || go_row) begin
         wait_r  <= 1'b1;
      end else if (ld_r) begin
         dq_r    <= ARR_DATA;
         wait_r  <= 1'b0;
         drive_r <= 1'b1;
      end else if (step && last) begin
         drive_r <= 1'b0; // words held until the burst ends
      end
   end

   assign ARR_ADDR    = addr_r;
   assign DQ_O        = dq_r;
   assign DQ_OE_N     = !drive_r;
   assign WAIT_O      = wait_r;
   assign WAIT_OE_N   = pin.ce_n;
   assign cfg_if.stat = {addr_r, 8'h0, rw_done_r, crossed_r,
                         (state_r != ST_IDLE && state_r != ST_DONE), 3'(state_r)};

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   AST_WRAP_GROUP: assert property (
      step && !last && !bw_q && !cont |=>
         (addr_r & ~(ADDR_W'(burst_words(bl_q)) - ADDR_W'(1)))
         == ($past(addr_r) & ~(ADDR_W'(burst_words(bl_q)) - ADDR_W'(1))))
      else $error("wrap burst left its aligned group");

   AST_NOWRAP_INC: assert property (
      step && !last && bw_q |=> addr_r == $past(addr_r) + ADDR_W'(1))
      else $error("no-wrap burst did not increment by one");

   AST_CONT_INC: assert property (
      step && !last && cont |=> addr_r == $past(addr_r) + ADDR_W'(1))
      else $error("continuous burst did not advance linearly");

   AST_ALIGNED_NOWAIT: assert property (
      state_r == ST_ROWW |-> off_r != GROUP_ALIGN && !dh_q && bw_q)
      else $error("row wait inserted for aligned or disallowed burst");

   AST_ROW_MAX: assert property (
      $rose(state_r == ST_ROWW) |-> rw_r <= lc_q - 3'h1 && rw_r != 3'h0)
      else $error("row wait count out of range");

   AST_ROW_ONCE: assert property (
      $rose(state_r == ST_ROWW) |-> !$past(crossed_r))
      else $error("second row-crossing delay in one burst");

   AST_WAIT_ROW: assert property (
      state_r == ST_ROWW |-> WAIT_O && !WAIT_OE_N)
      else $error("wait not asserted during row wait");

   AST_WAIT_LAT: assert property (
      state_r == ST_LAT && !pin.ce_n |-> WAIT_O)
      else $error("wait not asserted during first latency");

   AST_WAIT_DATA: assert property (
      ld_r && !pin.ce_n |=> !WAIT_O && !DQ_OE_N)
      else $error("wait still high once data valid");

   AST_READ_MODE: assert property (
      state_r == ST_IDLE && rm |=> state_r == ST_IDLE)
      else $error("burst started in asynchronous read mode");

   AST_EDGE_ONLY: assert property (
      state_r != $past(state_r) |-> $past(pin.ev) || $past(pin.ce_n))
      else $error("burst state moved off the active edge");

   AST_HOLD_TWO: assert property (
      state_r == ST_DATA && dh_q && pin.ev && !hold_r |-> !step)
      else $error("two-clock hold word left after one edge");

   AST_LEN_END: assert property (
      step && last && !cont && !pin.ce_n |=> state_r == ST_DONE)
      else $error("fixed burst did not end after its length");

   COV_WRAP4: cover property (step && last && !bw_q && bl_q == BL_4);
   COV_ROW_WAIT: cover property ($rose(state_r == ST_ROWW));
   COV_CONT: cover property (step && cont && nxt_a[3:0] == ROW_START);
   COV_FALL: cover property (start && !cfg_if.cfg[CE_BIT]);

endmodule : fbs_sequencer

// ---- inc/fbs_pkg.sv ----
package fbs_pkg;

   // register offsets on the apb window
   localparam logic [7:0]  CFG_OFF      = 8'h00;
   localparam logic [7:0]  STAT_OFF     = 8'h04;

   // read_config_reg field positions
   localparam int          RM_BIT       = 15;
   localparam int          LC_LSB       = 11;
   localparam int          WP_BIT       = 10;
   localparam int          DH_BIT       = 9;
   localparam int          WD_BIT       = 8;
   localparam int          BS_BIT       = 7;
   localparam int          CE_BIT       = 6;
   localparam int          BW_BIT       = 3;
   localparam int          BL_LSB       = 0;

   // reset value and writable bits (reserved bits and linear-only bit fixed)
   localparam logic [15:0] CFG_RST      = 16'hbfcf;
   localparam logic [15:0] CFG_WMASK    = 16'hbf4f;
   localparam logic [15:0] CFG_FIXED    = 16'h0080;

   // burst_length_field codes
   localparam logic [2:0]  BL_4         = 3'h1;
   localparam logic [2:0]  BL_8         = 3'h2;
   localparam logic [2:0]  BL_16        = 3'h3;
   localparam logic [2:0]  BL_CONT      = 3'h7;

   // device-row alignment and 4-word group size
   localparam logic [1:0]  GROUP_ALIGN  = 2'h0;
   localparam logic [3:0]  ROW_START    = 4'h0;
   localparam logic [3:0]  ROW_BIAS     = 4'h4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LAT,
      ST_DATA,
      ST_ROWW,
      ST_DONE
   } fbs_state_t;

   // wait states at the first row crossing: none when 4-word aligned,
   // first_access_latency-1 when starting on the last word of a group
   function automatic logic [2:0] fbs_row_waits(input logic [2:0] lc,
                                                input logic [1:0] off);
      logic [3:0] s;
      s = {1'b0, lc} + {2'b00, off};
      if (off == GROUP_ALIGN || s <= ROW_BIAS)
         return 3'h0;
      return 3'(s - ROW_BIAS);
   endfunction : fbs_row_waits

endpackage : fbs_pkg

// ---- inc/fbs_if.sv ----
`timescale 1ns/1ns

// synchronised link pins, seen in the system clock domain
interface fbs_pin_if #(parameter int ADDR_W = 16);
   logic              ev;
   logic              adv_n;
   logic              ce_n;
   logic [ADDR_W-1:0] addr;
   modport src (output ev, output adv_n, output ce_n, output addr);
   modport snk (input ev, input adv_n, input ce_n, input addr);
endinterface : fbs_pin_if

// configuration out of the register file, status back into it
interface fbs_cfg_if;
   logic [15:0] cfg;
   logic [31:0] stat;
   modport regs (output cfg, input stat);
   modport seq (input cfg, output stat);
endinterface : fbs_cfg_if

// ---- hdl/fbs_pin_sync.sv ----
`timescale 1ns/1ns

module fbs_pin_sync import fbs_pkg::*; #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RESET_N,
   // raw link pins
   input  wire logic              BURST_CLK,
   input  wire logic              ADV_N,
   input  wire logic              CE_N,
   input  wire logic [ADDR_W-1:0] ADDR,
   // selected active edge, from the clock-edge bit
   input  wire logic              rise_sel,
   // synchronised view
   fbs_pin_if.src                 pin
);

   logic [2:0]        bclk_r;
   logic [1:0]        adv_r;
   logic [1:0]        ce_r;
   logic [ADDR_W-1:0] addr1_r;
   logic [ADDR_W-1:0] addr2_r;

   // burst clock: two stages, third only for edge finding
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         bclk_r <= 3'h0;
      else
         bclk_r <= {bclk_r[1:0], BURST_CLK};
   end

   // strobes idle high; address is stable around the strobe so plain
   // two-stage sampling of the bus is enough
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         adv_r   <= 2'h3;
         ce_r    <= 2'h3;
         addr1_r <= '0;
         addr2_r <= '0;
      end else begin
         adv_r   <= {adv_r[0], ADV_N};
         ce_r    <= {ce_r[0], CE_N};
         addr1_r <= ADDR;
         addr2_r <= addr1_r;
      end
   end

   // one-cycle pulse on the chosen burst clock edge
   assign pin.ev    = rise_sel ? (bclk_r[1] & ~bclk_r[2])
                               : (~bclk_r[1] & bclk_r[2]);
   assign pin.adv_n = adv_r[1];
   assign pin.ce_n  = ce_r[1];
   assign pin.addr  = addr2_r;

endmodule : fbs_pin_sync

// ---- hdl/fbs_apb_regs.sv ----
`timescale 1ns/1ns

module fbs_apb_regs import fbs_pkg::*; (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // config and status
   fbs_cfg_if.regs          cfg_if
);

   logic [15:0] cfg_r;
   logic [31:0] rdata_r;
   logic        hit;

   assign hit = (PADDR == CFG_OFF) || (PADDR == STAT_OFF);

   // config write in the access phase; linear-only bit stays set
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         cfg_r <= CFG_RST;
      else if (PSEL && PENABLE && PWRITE && PADDR == CFG_OFF)
         cfg_r <= (PWDATA[15:0] & CFG_WMASK) | CFG_FIXED;
   end

   // read data captured in setup so it is a flop by the access phase
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         rdata_r <= 32'h0;
      else if (PSEL && !PENABLE && !PWRITE) begin
         if (PADDR == CFG_OFF)
            rdata_r <= {16'h0, cfg_r};
         else if (PADDR == STAT_OFF)
            rdata_r <= cfg_if.stat;
         else
            rdata_r <= 32'h0;
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign PREADY     = 1'b1;
   assign PSLVERR    = PSEL && PENABLE && !hit;
   assign PRDATA     = rdata_r;
   assign cfg_if.cfg = cfg_r;

endmodule : fbs_apb_regs

// ---- dv/fbs_host_model.sv ----
`timescale 1ns/1ns

// burst host: the link clock stands still low outside a frame
module fbs_host_model (
   // system clock
   input  wire logic        clk,
   // link pins toward the device
   output logic             burst_clk,
   output logic             adv_n,
   output logic             ce_n,
   output logic [15:0]      addr,
   // index of the active edge within the frame
   output int               edge_cnt
);
   // idle pins at time zero
   initial begin
      burst_clk = 1'b0;
      adv_n     = 1'b1;
      ce_n      = 1'b1;
      addr      = 16'h0000;
      edge_cnt  = -1;
   end

   // one frame of n link periods, strobe over the first one
   task automatic burst(input logic [15:0] a, input logic rise,
                        input int n);
      @(posedge clk);
      ce_n     <= 1'b0;
      adv_n    <= 1'b0;
      addr     <= a;
      edge_cnt <= -1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         burst_clk <= 1'b1;
         if (rise) edge_cnt <= edge_cnt + 1;
         repeat (4) @(posedge clk);
         burst_clk <= 1'b0;
         if (!rise) edge_cnt <= edge_cnt + 1;
         repeat (4) @(posedge clk);
         // released address shows its inverse, never a held copy
         if (i == 0) begin
            adv_n <= 1'b1;
            addr  <= ~a;
         end
      end
      // let the last word land before deselecting
      repeat (8) @(posedge clk);
      ce_n <= 1'b1;
      @(posedge clk);
   endtask : burst
endmodule : fbs_host_model

// ---- dv/fbs_sequencer_tb.sv ----
`timescale 1ns/1ns

module fbs_sequencer_tb import fbs_pkg::*;;
   localparam int          LIMIT   = 30000;
   localparam logic [15:0] XOR_PAT = 16'h5a3c;
   logic        clk, reset_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic        pready, pslverr, err, vprev;
   logic        bclk, adv_n, ce_n, dq_oe_n, wait_o, wait_oe_n;
   logic [15:0] addr, arr_addr, dq, last;
   logic [2:0]  bls[4] = '{BL_4, BL_8, BL_16, BL_CONT};
   int          edge_cnt, err_total, n_checks, cyc, seed, wo_bad;
   logic [15:0] cap_d[$];
   int          cap_e[$], exp_a[$], exp_e[$];

   // array content is a fixed pattern of the word address
   fbs_sequencer fbs_sequencer_i (.CLK(clk), .RESET_N(reset_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BURST_CLK(bclk), .ADV_N(adv_n), .CE_N(ce_n),
      .ADDR(addr), .ARR_ADDR(arr_addr), .ARR_DATA(arr_addr ^ XOR_PAT),
      .DQ_O(dq), .DQ_OE_N(dq_oe_n), .WAIT_O(wait_o), .WAIT_OE_N(wait_oe_n));

   fbs_host_model fbs_host_model_i (.clk(clk), .burst_clk(bclk),
      .adv_n(adv_n), .ce_n(ce_n), .addr(addr), .edge_cnt(edge_cnt));

   // 50 MHz system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // take each new word the host may sample, none while wait is up
   always @(posedge clk) begin
      if (dq_oe_n === 1'b0 && wait_o === 1'b0 && (!vprev || dq !== last))
      begin
         cap_d.push_back(dq);
         cap_e.push_back(edge_cnt);
         if (wait_oe_n !== 1'b0) wo_bad++;
      end
      vprev <= dq_oe_n === 1'b0 && wait_o === 1'b0;
      last  <= dq;
   end

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total = err_total + 1;
         stop_test();
      end
   end

   task automatic chk_data(input string what, input logic [31:0] e,
                           input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk_data

   task automatic chk_cnt(input string what, input int e, input int g);
      n_checks++;
      if (g != e) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", what, e, g);
      end
   endtask : chk_cnt

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   // one apb transfer; held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] d,
                      output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // model the word order and timing, configure, run a frame, compare
   task automatic run_burst(input logic rm, input logic [15:0] s,
                            input logic [2:0] bl, input logic bw, dh, ce,
                            input int lc, input int n);
      logic [15:0] c;
      int          len, hold, w, off, a, e, add;
      len  = bl == BL_4 ? 4 : bl == BL_8 ? 8 : bl == BL_16 ? 16 : 65536;
      hold = dh ? 2 : 1;
      off  = int'(s[1:0]);
      w    = (bw && !dh && off != 0 && lc + off > 4) ? lc + off - 4 : 0;
      if (n == 0) n = lc + len * hold + w + 4;
      add  = 0;
      exp_a.delete();
      exp_e.delete();
      for (int k = 0; k < len && !rm; k++) begin
         a = int'(s) + k;
         if (!bw && len < 65536) a = (int'(s) & -len) | (a & (len - 1));
         if (a > 65535) break;
         // first row crossing only, and only without wrap
         if (k > 0 && a % 16 == 0 && bw && add == 0) add = w;
         e = lc + k * hold + add;
         if (e > n - 1) break;
         exp_a.push_back(a);
         exp_e.push_back(e);
      end
      c = CFG_FIXED;
      c[RM_BIT] = rm;
      c[LC_LSB +: 3] = 3'(lc);
      c[WP_BIT] = 1'b1;
      c[DH_BIT] = dh;
      c[CE_BIT] = ce;
      c[BW_BIT] = bw;
      c[BL_LSB +: 3] = bl;
      apb(1'b1, CFG_OFF, {16'h0, c}, rd, err);
      cap_d.delete();
      cap_e.delete();
      wo_bad = 0;
      fbs_host_model_i.burst(s, ce, n);
      repeat (4) @(posedge clk);
      chk_cnt("word count", exp_a.size(), cap_d.size());
      foreach (cap_d[i]) if (i < exp_a.size()) begin
         chk_data("word", {16'h0, 16'(exp_a[i]) ^ XOR_PAT},
                  {16'h0, cap_d[i]});
         chk_cnt("data edge", exp_e[i], cap_e[i]);
      end
      chk_cnt("wait enable in frame", 0, wo_bad);
      chk_data("wait enable idle", 32'h1, {31'h0, wait_oe_n});
      // row waits seen through the status word, at most one delay a burst
      apb(1'b0, STAT_OFF, 32'h0, rd, err);
      chk_cnt("row waits", add, int'(rd[7:5]));
   endtask : run_burst

   // main sequence
   initial begin
      seed      = 32'he6b7;
      err_total = 0;
      n_checks  = 0;
      cyc       = 0;
      vprev     = 1'b0;
      last      = 16'h0000;
      reset_n   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, CFG_OFF, 32'h0, rd, err);
      chk_data("config reset", {16'h0, CFG_RST}, rd);
      run_burst(1, 16'h0004, BL_4, 1, 1, 1, 3, 12);
      apb(1'b1, CFG_OFF, 32'h0, rd, err);
      apb(1'b0, CFG_OFF, 32'h0, rd, err);
      chk_data("config fixed bits", {16'h0, CFG_FIXED}, rd);
      apb(1'b0, 8'h08, 32'h0, rd, err);
      chk_data("unmapped error", 32'h1, {31'h0, err});
      chk_data("unmapped data", 32'h0, rd);
      run_burst(0, 16'h0001, BL_4, 0, 1, 1, 3, 0);
      run_burst(0, 16'h0003, BL_4, 1, 1, 0, 2, 0);
      run_burst(0, 16'h0005, BL_8, 0, 0, 1, 4, 0);
      run_burst(0, 16'h000e, BL_16, 0, 0, 1, 3, 0);
      run_burst(0, 16'h00fe, BL_16, 1, 0, 1, 3, 0);
      run_burst(0, 16'h00fd, BL_16, 1, 0, 0, 3, 0);
      run_burst(0, 16'h002f, BL_8, 1, 0, 0, 4, 0);
      run_burst(0, 16'h002e, BL_8, 1, 1, 1, 4, 0);
      run_burst(0, 16'h000c, BL_8, 1, 0, 1, 4, 0);
      run_burst(0, 16'h001d, BL_CONT, 0, 0, 1, 3, 30);
      run_burst(0, 16'h000e, BL_CONT, 1, 0, 1, 4, 40);
      run_burst(0, 16'hfffa, BL_CONT, 1, 0, 0, 2, 14);
      for (int j = 0; j < 6; j++) begin
         r = $random(seed);
         run_burst(0, {4'h0, r[27:16]}, bls[r[1:0]], r[2], r[3], r[4],
                   int'(r[6:5]) % 3 + 2,
                   bls[r[1:0]] == BL_CONT ? 24 : 0);
      end
      stop_test();
   end
endmodule : fbs_sequencer_tb
